//--- core/svd_pkg.sv
`default_nettype none
// =============================================================================
// Shared constants for the supply voltage detect block.
package svd_pkg;

   // =========================================================================
   // Register bus geometry and register byte addresses.
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] OFF_CTRL       = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;

   // =========================================================================
   // Field positions.
   localparam int unsigned BIT_ENABLE      = 0;
   localparam int unsigned BIT_LOW_FLAG    = 1;
   localparam int unsigned BIT_HIGH_FLAG   = 2;
   localparam int unsigned BIT_IRQ_SETTLED = 0;
   localparam int unsigned BIT_IRQ_LOW     = 5;
   localparam logic [7:0] IRQ_IMPL_BITS    = 8'h21;

   // =========================================================================
   // Values after reset.
   localparam logic       ENABLE_RESET     = 1'b0;
   localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET   = 8'h00;
   localparam logic [7:0] RDATA_RESET      = 8'h00;

   // =========================================================================
   // Settling time after enable, and its cycle count rounded up.
   localparam int unsigned SETTLE_TIME_NS = 20000;
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_CNT_W   = 12;
   localparam logic [11:0] SETTLE_LAST    = 12'(SETTLE_CYC - 1);
   localparam logic [11:0] SETTLE_CYC_W   = 12'(SETTLE_CYC);

   // =========================================================================
   // Comparator inputs: bit 0 is below-low, bit 1 is above-high.
   localparam int unsigned CMP_W    = 2;
   localparam int unsigned CMP_LOW  = 0;
   localparam int unsigned CMP_HIGH = 1;

   typedef enum logic [2:0] {
      SVD_OFF      = 3'h1,
      SVD_SETTLING = 3'h2,
      SVD_MONITOR  = 3'h4
   } svd_state_t;

endpackage
`default_nettype wire

//--- core/svd_sync3.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// Three-stage synchroniser; the output moves only when stages two and three agree.
module svd_sync3 (
   input  wire logic                     core_clk_i, // Core clock.
   input  wire logic                     reset_i,    // Synchronous reset, active high.
   input  wire logic [svd_pkg::CMP_W-1:0] async_i,   // Asynchronous comparator levels.
   output logic      [svd_pkg::CMP_W-1:0] stable_o   // Filtered, synchronous levels.
);

   logic [svd_pkg::CMP_W-1:0] stage1;
   logic [svd_pkg::CMP_W-1:0] stage2;
   logic [svd_pkg::CMP_W-1:0] stage3;

   genvar g;
   generate
      for (g = 0; g < svd_pkg::CMP_W; g = g + 1) begin : g_bit
         always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
               stage1[g]   <= 1'b0;
               stage2[g]   <= 1'b0;
               stage3[g]   <= 1'b0;
               stable_o[g] <= 1'b0;
            end else begin
               stage1[g] <= async_i[g];
               stage2[g] <= stage1[g];
               stage3[g] <= stage2[g];
               if (stage2[g] == stage3[g]) begin
                  stable_o[g] <= stage3[g];
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

//--- core/svd_settle_timer.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// Counts the settling window after enable; restarts whenever run drops.
module svd_settle_timer (
   input  wire logic core_clk_i, // Core clock.
   input  wire logic reset_i,    // Synchronous reset, active high.
   input  wire logic run_i,      // Monitoring enabled.
   output logic      done_o      // Settling window over, level.
);

   logic [svd_pkg::SETTLE_CNT_W-1:0] count;
   logic                             at_last;

   assign at_last = (count == svd_pkg::SETTLE_LAST);

   always_ff @(posedge core_clk_i) begin
      if (reset_i || !run_i) begin
         count  <= '0;
         done_o <= 1'b0;
      end else if (!done_o) begin
         count  <= at_last ? count : count + 12'h001;
         done_o <= at_last;
      end
   end

endmodule
`default_nettype wire

//--- core/svd_supply_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// How it works
// RQ1: Control bit 0 enables monitoring, read/write, cleared by reset.
// RQ2: While enabled, flags follow the synchronised comparators every cycle.
// RQ3: Flags count as valid only 20 us after enable; they read zero before.
// RQ4: Bit 2 high-supply flag is set only while supply exceeds high threshold.
// RQ5: Bit 1 low-supply flag is set only while supply is below low threshold.
// RQ6: With monitoring on, the low-supply flag raises request bit 5.
// RQ7: Request bit 5 stays latched until software reads it or reset.
// RQ8: Request reaches the interrupt output only when its mask bit is set.
// RQ9: Software enables interrupts globally before enabling detection at power-up.
// RQ10: Software avoids port 0/1 mode writes while checking for low supply.
// RQ11: Software disables detection before entering stop mode.
// RQ12: Flag and reserved bit writes are ignored; flags read zero when disabled.
module svd_supply_monitor (
   input  wire logic                       core_clk_i,              // Core clock, 100 MHz.
   input  wire logic                       reset_i,                 // Sync reset, active high.
   input  wire logic [svd_pkg::ADDR_W-1:0] reg_addr_i,              // Register byte address.
   input  wire logic [svd_pkg::DATA_W-1:0] reg_wdata_i,             // Write data.
   input  wire logic                       reg_wr_i,                // Write strobe.
   input  wire logic                       reg_rd_i,                // Read strobe.
   output logic      [svd_pkg::DATA_W-1:0] reg_rdata_o,             // Read data, cycle after read.
   input  wire logic                       above_high_i,            // Comparator, async.
   input  wire logic                       below_low_i,             // Comparator, async.
   output logic                            supply_monitor_enable_o, // Powers the comparators.
   output logic                            irq_o                    // Interrupt, level, high.
);

   // =========================================================================
   // State.
   logic                       supply_monitor_enable;
   logic                       high_supply_flag;
   logic                       low_supply_flag;
   logic [svd_pkg::DATA_W-1:0] irq_status;
   logic [svd_pkg::DATA_W-1:0] irq_mask_register;
   logic                       settled_d;
   svd_pkg::svd_state_t        state;
   svd_pkg::svd_state_t        next_state;

   logic [svd_pkg::CMP_W-1:0]  cmp_sync;
   logic                       settled;

   // =========================================================================
   // Decode and selection.
   logic                       wr_ctrl;
   logic                       wr_mask;
   logic                       rd_status;
   logic                       next_enable;
   logic                       monitoring;
   logic                       next_high_flag;
   logic                       next_low_flag;
   logic [svd_pkg::DATA_W-1:0] irq_set;
   logic [svd_pkg::DATA_W-1:0] irq_clear;
   logic [svd_pkg::DATA_W-1:0] next_irq_status;
   logic [svd_pkg::DATA_W-1:0] ctrl_view;
   logic [svd_pkg::DATA_W-1:0] rd_mux;
   logic                       irq_pending;

   assign wr_ctrl   = reg_wr_i && (reg_addr_i == svd_pkg::OFF_CTRL);
   assign wr_mask   = reg_wr_i && (reg_addr_i == svd_pkg::OFF_IRQ_MASK);
   assign rd_status = reg_rd_i && (reg_addr_i == svd_pkg::OFF_IRQ_STATUS);

   // RQ1 enable bit write
   assign next_enable = wr_ctrl ? reg_wdata_i[svd_pkg::BIT_ENABLE] : supply_monitor_enable;

   assign monitoring = next_enable && (state == svd_pkg::SVD_MONITOR);

   // RQ4 high flag qualify
   assign next_high_flag = monitoring && cmp_sync[svd_pkg::CMP_HIGH];
   // RQ5 low flag qualify
   assign next_low_flag  = monitoring && cmp_sync[svd_pkg::CMP_LOW];

   // RQ6 low raises request
   assign irq_set = {2'h0, low_supply_flag, 4'h0, settled && !settled_d};

   // Read clears the status, but a set in the same cycle wins so no event is lost.
   assign irq_clear       = rd_status ? svd_pkg::IRQ_IMPL_BITS : 8'h00;
   // RQ7 latch until read
   assign next_irq_status = ((irq_status & ~irq_clear) | irq_set) & svd_pkg::IRQ_IMPL_BITS;

   // RQ12 reserved bits zero
   assign ctrl_view = {5'h00, high_supply_flag, low_supply_flag, supply_monitor_enable};

   assign rd_mux = (reg_addr_i == svd_pkg::OFF_CTRL)       ? ctrl_view :
                   (reg_addr_i == svd_pkg::OFF_IRQ_STATUS) ? irq_status :
                   (reg_addr_i == svd_pkg::OFF_IRQ_MASK)   ? irq_mask_register :
                                                             8'h00;

   // RQ8 mask gates request
   assign irq_pending = |(irq_status & irq_mask_register);

   // =========================================================================
   // Comparator synchroniser and settling timer.
   svd_sync3 u_sync (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .async_i    ({above_high_i, below_low_i}),
      .stable_o   (cmp_sync)
   );

   // RQ3 settle window timer
   svd_settle_timer u_settle (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .run_i      (supply_monitor_enable),
      .done_o     (settled)
   );

   // =========================================================================
   // Monitor state machine.
   always_comb begin
      next_state = state;
      case (state)
         svd_pkg::SVD_OFF: begin
            if (supply_monitor_enable) begin
               next_state = svd_pkg::SVD_SETTLING;
            end
         end
         svd_pkg::SVD_SETTLING: begin
            if (!supply_monitor_enable) begin
               next_state = svd_pkg::SVD_OFF;
            end else if (settled) begin
               next_state = svd_pkg::SVD_MONITOR;
            end
         end
         svd_pkg::SVD_MONITOR: begin
            if (!supply_monitor_enable) begin
               next_state = svd_pkg::SVD_OFF;
            end
         end
         default: begin
            next_state = svd_pkg::SVD_OFF;
         end
      endcase
   end

   // =========================================================================
   // Registers.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state                 <= svd_pkg::SVD_OFF;
         supply_monitor_enable <= svd_pkg::ENABLE_RESET;
         settled_d             <= 1'b0;
      end else begin
         state                 <= next_state;
         supply_monitor_enable <= next_enable;
         settled_d             <= settled;
      end
   end

   // Flags track the comparators every cycle rather than on a software request.
   // RQ2 real time update
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         high_supply_flag <= 1'b0;
         low_supply_flag  <= 1'b0;
      end else begin
         high_supply_flag <= next_high_flag;
         low_supply_flag  <= next_low_flag;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         irq_status        <= svd_pkg::IRQ_STATUS_RESET;
         irq_mask_register <= svd_pkg::IRQ_MASK_RESET;
         irq_o             <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (wr_mask) begin
            irq_mask_register <= reg_wdata_i & svd_pkg::IRQ_IMPL_BITS;
         end
         irq_o <= irq_pending;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         reg_rdata_o             <= svd_pkg::RDATA_RESET;
         supply_monitor_enable_o <= svd_pkg::ENABLE_RESET;
      end else begin
         reg_rdata_o             <= reg_rd_i ? rd_mux : 8'h00;
         supply_monitor_enable_o <= next_enable;
      end
   end

   // =========================================================================
   // Checks. The age counter lets a long wait be checked without a huge repeat.
   logic [svd_pkg::SETTLE_CNT_W-1:0] en_age;

   always_ff @(posedge core_clk_i) begin
      if (reset_i || !supply_monitor_enable) begin
         en_age <= '0;
      end else if (en_age != 12'hFFF) begin
         en_age <= en_age + 12'h001;
      end
   end

   property p_enable_write;
      @(posedge core_clk_i) disable iff (reset_i)
      wr_ctrl |=> (supply_monitor_enable == $past(reg_wdata_i[svd_pkg::BIT_ENABLE]));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("Enable bit not written."); // RQ1

   property p_realtime;
      @(posedge core_clk_i) disable iff (reset_i)
      (monitoring && $changed(cmp_sync[svd_pkg::CMP_LOW]))
         |=> (low_supply_flag == $past(cmp_sync[svd_pkg::CMP_LOW]));
   endproperty
   a_realtime: assert property (p_realtime) else $error("Low flag did not track supply."); // RQ2

   property p_high_realtime;
      @(posedge core_clk_i) disable iff (reset_i)
      (monitoring && $changed(cmp_sync[svd_pkg::CMP_HIGH]))
         |=> (high_supply_flag == $past(cmp_sync[svd_pkg::CMP_HIGH]));
   endproperty
   a_high_realtime: assert property (p_high_realtime) else $error("High flag lagged."); // RQ2

   property p_settle;
      @(posedge core_clk_i) disable iff (reset_i)
      (low_supply_flag || high_supply_flag) |-> (en_age > svd_pkg::SETTLE_CYC_W);
   endproperty
   a_settle: assert property (p_settle) else $error("Flag raised inside settle window."); // RQ3

   property p_settle_event;
      @(posedge core_clk_i) disable iff (reset_i)
      (settled && !settled_d) |=> irq_status[svd_pkg::BIT_IRQ_SETTLED];
   endproperty
   a_settle_event: assert property (p_settle_event) else $error("Settle event lost."); // RQ3

   property p_high_flag;
      @(posedge core_clk_i) disable iff (reset_i)
      high_supply_flag |-> ($past(cmp_sync[svd_pkg::CMP_HIGH]) && supply_monitor_enable);
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("High flag without high supply."); // RQ4

   property p_low_flag;
      @(posedge core_clk_i) disable iff (reset_i)
      low_supply_flag |-> ($past(cmp_sync[svd_pkg::CMP_LOW]) && supply_monitor_enable);
   endproperty
   a_low_flag: assert property (p_low_flag) else $error("Low flag without low supply."); // RQ5

   property p_low_request;
      @(posedge core_clk_i) disable iff (reset_i)
      low_supply_flag |=> irq_status[svd_pkg::BIT_IRQ_LOW];
   endproperty
   a_low_request: assert property (p_low_request) else $error("Low flag raised no request."); // RQ6

   property p_request_held;
      @(posedge core_clk_i) disable iff (reset_i)
      (irq_status[svd_pkg::BIT_IRQ_LOW] && !rd_status) |=> irq_status[svd_pkg::BIT_IRQ_LOW];
   endproperty
   a_request_held: assert property (p_request_held) else $error("Request lost before read."); // RQ7

   property p_masked_in;
      @(posedge core_clk_i) disable iff (reset_i)
      (irq_status[svd_pkg::BIT_IRQ_LOW] && irq_mask_register[svd_pkg::BIT_IRQ_LOW]) |=> irq_o;
   endproperty
   a_masked_in: assert property (p_masked_in) else $error("Unmasked request not delivered."); // RQ8

   property p_masked_out;
      @(posedge core_clk_i) disable iff (reset_i)
      !irq_pending |=> !irq_o;
   endproperty
   a_masked_out: assert property (p_masked_out) else $error("Interrupt without unmasked request."); // RQ8

   property p_mask_write;
      @(posedge core_clk_i) disable iff (reset_i)
      wr_mask |=> (irq_mask_register == ($past(reg_wdata_i) & svd_pkg::IRQ_IMPL_BITS));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("Mask write lost."); // RQ8

   property p_disabled_zero;
      @(posedge core_clk_i) disable iff (reset_i)
      !supply_monitor_enable |-> (!low_supply_flag && !high_supply_flag);
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("Flag set while disabled."); // RQ12

   property p_flag_write_ignored;
      @(posedge core_clk_i) disable iff (reset_i)
      (wr_ctrl && !monitoring) |=> (!low_supply_flag && !high_supply_flag);
   endproperty
   a_flag_write_ignored: assert property (p_flag_write_ignored) else $error("Flag took write."); // RQ12

   property p_cov_low_irq;
      @(posedge core_clk_i) disable iff (reset_i)
      low_supply_flag ##1 irq_o;
   endproperty
   c_low_irq: cover property (p_cov_low_irq);

   property p_cov_settled;
      @(posedge core_clk_i) disable iff (reset_i)
      (state == svd_pkg::SVD_SETTLING) ##1 (state == svd_pkg::SVD_MONITOR);
   endproperty
   c_settled: cover property (p_cov_settled);

   property p_cov_read_clear;
      @(posedge core_clk_i) disable iff (reset_i)
      (rd_status && irq_status[svd_pkg::BIT_IRQ_LOW] && !low_supply_flag)
         ##1 !irq_status[svd_pkg::BIT_IRQ_LOW];
   endproperty
   c_read_clear: cover property (p_cov_read_clear);

endmodule
`default_nettype wire

//--- sim/tb_svd_supply_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tb_svd_supply_monitor;
   logic       core_clk_i = 1'b0;
   logic       reset_i    = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i   = 1'b0;
   logic       reg_rd_i   = 1'b0;
   logic       above_high_i = 1'b0;
   logic       below_low_i  = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       supply_monitor_enable_o;
   logic       irq_o;
   int         n_mismatch   = 0;
   int         total_checks = 0;
   int         cyc          = 0;
   // Bench model of the register file, kept in plain integers.
   int         m_en = 0;
   int         m_settled = 0;
   int         m_mask = 0;
   int         m_stat = 0;
   int         m_hi = 0;
   int         m_lo = 0;
   logic [31:0] seed = 32'h0000B374;
   logic [7:0]  a;

   svd_supply_monitor dut_u (
      .core_clk_i              (core_clk_i),
      .reset_i                 (reset_i),
      .reg_addr_i              (reg_addr_i),
      .reg_wdata_i             (reg_wdata_i),
      .reg_wr_i                (reg_wr_i),
      .reg_rd_i                (reg_rd_i),
      .reg_rdata_o             (reg_rdata_o),
      .above_high_i            (above_high_i),
      .below_low_i             (below_low_i),
      .supply_monitor_enable_o (supply_monitor_enable_o),
      .irq_o                   (irq_o)
   );

   always #5 core_clk_i = ~core_clk_i;

   // ==========================================================================
   // Verdict and hang guard.
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The run needs two settling windows plus a few hundred bus cycles.
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end

   // ==========================================================================
   // Shared helpers.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] ctrl_exp();
      if (m_en == 0) return 8'h00;
      if (m_settled == 0) return 8'h01;
      return 8'(1 + 2 * m_lo + 4 * m_hi);
   endfunction

   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= ad;
      reg_wdata_i <= wd;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      if (ad == svd_pkg::OFF_CTRL) begin
         m_en = int'(wd[0]);
         m_settled = 0;
      end
      if (ad == svd_pkg::OFF_IRQ_MASK) m_mask = int'(wd) & 'h21;
   endtask

   // Read data stand for one cycle only, then the port returns to zero.
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= ad;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
      if (ad == svd_pkg::OFF_IRQ_STATUS) m_stat = (m_en && m_settled && m_lo) ? 'h20 : 0;
      @(posedge core_clk_i);
      #1;
      chk(reg_rdata_o, 8'h00);
   endtask

   task automatic set_supply(input int hi, input int lo);
      @(posedge core_clk_i);
      above_high_i <= hi[0];
      below_low_i  <= lo[0];
      m_hi = hi;
      m_lo = lo;
   endtask

   // Waits, lets the model latch a low supply, then compares the interrupt.
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
      if (m_en && m_settled && m_lo) m_stat = m_stat | 'h20;
      chk({7'h00, irq_o}, {7'h00, |(m_stat[7:0] & m_mask[7:0])});
   endtask

   // ==========================================================================
   // Main sequence.
   initial begin
      repeat (12) @(posedge core_clk_i);
      reset_i <= 1'b0;
      #1;
      chk({7'h00, supply_monitor_enable_o}, 8'h00);
      rd_chk(svd_pkg::OFF_CTRL, 8'h00);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'h00);
      rd_chk(svd_pkg::OFF_IRQ_MASK, 8'h00);
      wr(svd_pkg::OFF_CTRL, 8'hFE);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      wr(svd_pkg::OFF_IRQ_STATUS, 8'hFF);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'h00);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr_next(seed);
         a = seed[7:0];
         if (a == svd_pkg::OFF_CTRL || a == svd_pkg::OFF_IRQ_STATUS ||
             a == svd_pkg::OFF_IRQ_MASK) a = a ^ 8'h80;
         wr(a, seed[15:8]);
         rd_chk(a, 8'h00);
         wr(svd_pkg::OFF_IRQ_MASK, seed[23:16]);
         rd_chk(svd_pkg::OFF_IRQ_MASK, 8'(m_mask));
         rd_chk(svd_pkg::OFF_CTRL, 8'h00);
      end
      wr(svd_pkg::OFF_IRQ_MASK, 8'h20);
      set_supply(1, 1);
      wr(svd_pkg::OFF_CTRL, 8'hFF);
      #1;
      chk({7'h00, supply_monitor_enable_o}, 8'h01);
      repeat (1980) @(posedge core_clk_i);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      repeat (20) @(posedge core_clk_i);
      m_settled = 1;
      m_stat = m_stat | 'h01;
      hold(8);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      set_supply(1, 0);
      hold(8);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      set_supply(0, 0);
      hold(8);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      hold(4);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      wr(svd_pkg::OFF_IRQ_MASK, 8'h00);
      set_supply(0, 1);
      hold(8);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      set_supply(0, 0);
      hold(8);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      wr(svd_pkg::OFF_IRQ_MASK, 8'h21);
      set_supply(1, 1);
      hold(8);
      wr(svd_pkg::OFF_CTRL, 8'h00);
      #1;
      chk({7'h00, supply_monitor_enable_o}, 8'h00);
      rd_chk(svd_pkg::OFF_CTRL, ctrl_exp());
      hold(4);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'(m_stat));
      hold(4);
      wr(svd_pkg::OFF_IRQ_MASK, 8'h01);
      set_supply(0, 1);
      wr(svd_pkg::OFF_CTRL, 8'h01);
      repeat (2010) @(posedge core_clk_i);
      m_settled = 1;
      m_stat = m_stat | 'h01;
      hold(4);
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      reset_i <= 1'b0;
      m_en = 0;
      m_settled = 0;
      m_mask = 0;
      m_stat = 0;
      #1;
      chk({7'h00, irq_o}, 8'h00);
      chk({7'h00, supply_monitor_enable_o}, 8'h00);
      rd_chk(svd_pkg::OFF_IRQ_STATUS, 8'h00);
      rd_chk(svd_pkg::OFF_CTRL, 8'h00);
      rd_chk(svd_pkg::OFF_IRQ_MASK, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
